// ===== inc/lpm_pkg.sv
// Constants for the low power mode controller.
// Assumes a single 125 MHz core clock and a synchronous reset.
package lpm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 125;
  localparam int CLK_PER_MCYC   = 6;
  localparam int IDLE_RST_MCYC  = 2;
  localparam int IDLE_RST_CYC   = IDLE_RST_MCYC * CLK_PER_MCYC;
  localparam int OSC_SETTLE_MS  = 10;
  localparam int OSC_SETTLE_CYC = OSC_SETTLE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W          = 24;

  // ----------------------------------------------------------------
  // Power control bit positions
  // ----------------------------------------------------------------
  localparam int PC_IDLE_BIT    = 0;
  localparam int PC_PDOWN_BIT   = 1;
  localparam int PC_FLAG_BIT    = 4;
  localparam int PC_W           = 8;
  localparam logic [7:0] PC_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  localparam logic STROBE_IDLE  = 1'b1;
  localparam logic STROBE_PDOWN = 1'b0;

  // ----------------------------------------------------------------
  // Modes, Gray coded along run, idle, power-down, wake
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LPM_RUN   = 3'b000,
    LPM_IDLE  = 3'b001,
    LPM_PDOWN = 3'b011,
    LPM_WAKE  = 3'b010,
    LPM_FLOAT = 3'b110
  } lpm_mode_e;

endpackage

// ===== verilog/lpm_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes pins are asynchronous to core_clk.
`timescale 1ns/1ps
module lpm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // Levels
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_r  <= '0;
      syncOut <= '0;
    end else begin
      meta_r  <= pinIn;
      syncOut <= meta_r;
    end
  end

endmodule // lpm_sync

// ===== verilog/lpm_ctrl.sv
// Low power mode controller: idle, power-down, power-off flag, float mode.
// Assumes the CPU core, oscillator gate and pad cells sit outside.
// Notes on behaviour
// [RULE1] Stopped oscillator leaves RAM and register contents unchanged.
// [RULE2] Idle halts CPU execution; peripherals keep their clock. Code drives oscGate low while in idle.
// [RULE3] The instruction requesting idle completes and is the last one.
// [RULE4] CPU state, RAM and registers are held during idle.
// [RULE5] Any enabled interrupt ends idle and vectors to its handler.
// [RULE6] Reset during idle restarts exactly like power-on reset.
// [RULE7] Power-down stops the oscillator after the requesting instruction.
// [RULE8] Only reset or external interrupt leaves power-down.
// [RULE9] Reset out of power-down resets registers but keeps RAM.
// [RULE10] External interrupt wake keeps both registers and RAM.
// [RULE11] Outside party holds wake long enough for oscillator settle.
// [RULE12] Software enables both wake inputs as level triggered first.
// [RULE13] Low wake pin restarts oscillator; its return high completes exit.
// [RULE14] After return, execution continues past the power-down instruction.
// [RULE15] Power-off flag set on power-up; software can set and clear.
// [RULE16] Reset out of idle: two machine cycles, RAM writes blocked.
// [RULE17] Software avoids port or external writes right after idle entry.
// [RULE18] Address strobe low in reset with program strobe high enters float.
// [RULE19] Float mode floats port 0, weakly pulls others, oscillator runs.
// [RULE20] Only an ordinary reset leaves float mode.
// [RULE21] Idle strobes 1, power-down strobes 0; port 0/2 per program memory.
// [RULE22] Separate idle and power-down bits, cleared on exit.
`timescale 1ns/1ps
module lpm_ctrl #(
  parameter int OSC_SETTLE = lpm_pkg::OSC_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Supply and reset pin
  input  wire logic       powerUp,
  input  wire logic       resetPin,
  // Power control write from CPU
  input  wire logic       pcWrite,
  input  wire logic [7:0] pcWdata,
  output logic      [7:0] pcRdata,
  // CPU handshake
  input  wire logic       instrDone,
  input  wire logic       irqPending,
  input  wire logic       ramWriteReq,
  output logic            cpuHalt,
  output logic            cpuVector,
  output logic            cpuReset,
  output logic            ramWriteEn,
  output logic            regsReset,
  // Oscillator
  output logic            oscRun,
  output logic            oscGate,
  // Wake pins
  input  wire logic       ext_wake_irq_a,
  input  wire logic       ext_wake_irq_b,
  input  wire logic       wakeEnA,
  input  wire logic       wakeEnB,
  // Strobes and ports
  input  wire logic       extProgMem,
  input  wire logic       addrStrobeIn,
  input  wire logic       program_store_strobe,
  output logic            addrStrobeOut,
  output logic            addrStrobeOe,
  output logic            progStrobeOut,
  output logic            progStrobeOe,
  output logic            port0Oe,
  output logic            port2Addr,
  output logic            weakPullUp,
  output logic            floatMode,
  output logic            power_off_flag
);

  logic [5:0]           syncV;
  logic                 rstS;
  logic                 wakeAS;
  logic                 wakeBS;
  logic                 aleS;
  logic                 psenS;
  logic                 powerUpS;
  logic                 rstPrev_r;
  logic                 pupPrev_r;
  lpm_pkg::lpm_mode_e   mode_r;
  logic                 idleReq_r;
  logic                 pdReq_r;
  logic                 flag_r;
  logic                 flagEvt;
  logic [lpm_pkg::CNT_W-1:0] cnt_r;
  logic                 wakeLow;
  logic                 wakeHigh;
  logic                 idleRstWin;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  lpm_sync #(.W(6)) uSync (
    .core_clk (core_clk),
    .srst     (1'b0),
    .pinIn    ({resetPin, ext_wake_irq_a, ext_wake_irq_b, addrStrobeIn, program_store_strobe, powerUp}),
    .syncOut  (syncV)
  );
  assign {rstS, wakeAS, wakeBS, aleS, psenS, powerUpS} = syncV;

  function automatic logic anyLow(input logic a, input logic ea, input logic b, input logic eb);
    anyLow = (ea && !a) || (eb && !b);
  endfunction

  assign wakeLow  = anyLow(wakeAS, wakeEnA, wakeBS, wakeEnB);             // [RULE12]
  assign wakeHigh = !wakeLow;
  assign flagEvt  = powerUpS && !pupPrev_r;
  assign idleRstWin = (mode_r == lpm_pkg::LPM_IDLE) && rstS && (cnt_r < lpm_pkg::CNT_W'(lpm_pkg::IDLE_RST_CYC));

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rstPrev_r <= 1'b0;
    end else begin
      rstPrev_r <= rstS;
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_r <= lpm_pkg::LPM_RUN;
      cnt_r  <= '0;
    end else if (mode_r == lpm_pkg::LPM_FLOAT) begin
      if (rstS && !aleS) begin
        mode_r <= lpm_pkg::LPM_FLOAT;
      end else if (rstS) begin
        mode_r <= lpm_pkg::LPM_RUN;                                        // [RULE20]
      end
    end else if (rstPrev_r && !rstS && !aleS && psenS) begin
      mode_r <= lpm_pkg::LPM_FLOAT;                                        // [RULE18]
    end else begin
      case (mode_r)
        lpm_pkg::LPM_RUN: begin
          cnt_r <= '0;
          if (instrDone && pdReq_r) begin
            mode_r <= lpm_pkg::LPM_PDOWN;                                  // [RULE7]
          end else if (instrDone && idleReq_r) begin
            mode_r <= lpm_pkg::LPM_IDLE;                                   // [RULE3]
          end
        end
        lpm_pkg::LPM_IDLE: begin
          // CPU runs on through the reset window
          if (rstS) begin
            if (cnt_r >= lpm_pkg::CNT_W'(lpm_pkg::IDLE_RST_CYC)) begin
              mode_r <= lpm_pkg::LPM_RUN;                                  // [RULE6]
              cnt_r  <= '0;
            end else begin
              cnt_r <= cnt_r + 1'b1;                                       // [RULE16]
            end
          end else if (irqPending) begin
            mode_r <= lpm_pkg::LPM_RUN;                                    // [RULE5]
          end
        end
        lpm_pkg::LPM_PDOWN: begin
          cnt_r <= '0;
          if (rstS) begin
            mode_r <= lpm_pkg::LPM_RUN;                                    // [RULE8]
          end else if (wakeLow) begin
            mode_r <= lpm_pkg::LPM_WAKE;                                   // [RULE13]
          end
        end
        lpm_pkg::LPM_WAKE: begin
          // Settle count stops at its end value
          if (rstS) begin
            mode_r <= lpm_pkg::LPM_RUN;
          end else if (wakeHigh) begin
            mode_r <= lpm_pkg::LPM_RUN;                                    // [RULE13]
          end else if (cnt_r != lpm_pkg::CNT_W'(OSC_SETTLE)) begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          mode_r <= lpm_pkg::LPM_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power control bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || (rstS && mode_r != lpm_pkg::LPM_IDLE)) begin
      idleReq_r <= 1'b0;
      pdReq_r   <= 1'b0;
    end else if (mode_r == lpm_pkg::LPM_IDLE && (irqPending || rstS)) begin
      idleReq_r <= 1'b0;                                                   // [RULE22]
    end else if (mode_r == lpm_pkg::LPM_WAKE && wakeHigh) begin
      pdReq_r <= 1'b0;                                                     // [RULE22]
    end else if (pcWrite && mode_r == lpm_pkg::LPM_RUN) begin
      idleReq_r <= pcWdata[lpm_pkg::PC_IDLE_BIT];                          // [RULE22]
      pdReq_r   <= pcWdata[lpm_pkg::PC_PDOWN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Power-off flag, not touched by srst
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    // Supply edge history survives srst
    pupPrev_r <= powerUpS;
    if (flagEvt) begin
      flag_r <= 1'b1;                                                      // [RULE15]
    end else if (pcWrite) begin
      flag_r <= pcWdata[lpm_pkg::PC_FLAG_BIT];                             // [RULE15]
    end else if (!powerUpS) begin
      flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // CPU and oscillator controls
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpuHalt    <= 1'b0;
      cpuVector  <= 1'b0;
      cpuReset   <= 1'b1;
      ramWriteEn <= 1'b0;
      regsReset  <= 1'b1;
      oscRun     <= 1'b1;
      oscGate    <= 1'b1;
      pcRdata    <= lpm_pkg::PC_RESET;
    end else begin
      cpuHalt    <= (mode_r == lpm_pkg::LPM_IDLE && !idleRstWin) || mode_r == lpm_pkg::LPM_PDOWN
                    || mode_r == lpm_pkg::LPM_WAKE;                        // [RULE2] [RULE4]
      cpuVector  <= (mode_r == lpm_pkg::LPM_IDLE && irqPending && !rstS)
                    || (mode_r == lpm_pkg::LPM_WAKE && wakeHigh && !rstS); // [RULE5] [RULE14]
      cpuReset   <= rstS && !idleRstWin;                                   // [RULE6] [RULE9]
      ramWriteEn <= ramWriteReq && !rstS && mode_r == lpm_pkg::LPM_RUN;    // [RULE16] [RULE1]
      regsReset  <= rstS && !idleRstWin;                                   // [RULE9] [RULE10]
      oscRun     <= mode_r != lpm_pkg::LPM_PDOWN;                          // [RULE7] [RULE19]
      oscGate    <= mode_r == lpm_pkg::LPM_RUN || mode_r == lpm_pkg::LPM_FLOAT
                    || (mode_r == lpm_pkg::LPM_WAKE && cnt_r == lpm_pkg::CNT_W'(OSC_SETTLE));
      pcRdata    <= {3'h0, flag_r, 2'h0, pdReq_r, idleReq_r};
    end
  end

  // ----------------------------------------------------------------
  // Pin states
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addrStrobeOut  <= 1'b1;
      addrStrobeOe   <= 1'b1;
      progStrobeOut  <= 1'b1;
      progStrobeOe   <= 1'b1;
      port0Oe        <= 1'b1;
      port2Addr      <= 1'b0;
      weakPullUp     <= 1'b0;
      floatMode      <= 1'b0;
      power_off_flag <= 1'b0;
    end else begin
      power_off_flag <= flag_r;
      floatMode      <= mode_r == lpm_pkg::LPM_FLOAT;
      case (mode_r)
        lpm_pkg::LPM_FLOAT: begin
          addrStrobeOe <= 1'b0;                                            // [RULE19]
          progStrobeOe <= 1'b0;
          port0Oe      <= 1'b0;
          weakPullUp   <= 1'b1;
          port2Addr    <= 1'b0;
        end
        lpm_pkg::LPM_IDLE: begin
          addrStrobeOut <= lpm_pkg::STROBE_IDLE;                           // [RULE21]
          progStrobeOut <= lpm_pkg::STROBE_IDLE;
          addrStrobeOe  <= 1'b1;
          progStrobeOe  <= 1'b1;
          port0Oe       <= !extProgMem;
          port2Addr     <= extProgMem;
          weakPullUp    <= 1'b0;
        end
        lpm_pkg::LPM_PDOWN, lpm_pkg::LPM_WAKE: begin
          addrStrobeOut <= lpm_pkg::STROBE_PDOWN;                          // [RULE21]
          progStrobeOut <= lpm_pkg::STROBE_PDOWN;
          addrStrobeOe  <= 1'b1;
          progStrobeOe  <= 1'b1;
          port0Oe       <= !extProgMem;
          port2Addr     <= 1'b0;
          weakPullUp    <= 1'b0;
        end
        default: begin
          addrStrobeOut <= 1'b1;
          progStrobeOut <= 1'b1;
          addrStrobeOe  <= 1'b1;
          progStrobeOe  <= 1'b1;
          port0Oe       <= 1'b1;
          port2Addr     <= extProgMem;
          weakPullUp    <= 1'b0;
        end
      endcase
    end
  end

endmodule // lpm_ctrl

// ===== bench/lpm_ctrl_monitor.sv
// Port checker for the low power mode controller.
// Assumes it is bound onto lpm_ctrl running on core_clk.
`timescale 1ns/1ps
module lpm_ctrl_monitor (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       srst,
  // Inputs watched
  input wire logic       powerUp,
  input wire logic       resetPin,
  input wire logic       instrDone,
  input wire logic       irqPending,
  // Outputs watched
  input wire logic [7:0] pcRdata,
  input wire logic       cpuHalt,
  input wire logic       cpuVector,
  input wire logic       cpuReset,
  input wire logic       ramWriteEn,
  input wire logic       regsReset,
  input wire logic       oscRun,
  input wire logic       oscGate,
  input wire logic       addrStrobeOut,
  input wire logic       progStrobeOut,
  input wire logic       port0Oe,
  input wire logic       weakPullUp,
  input wire logic       floatMode,
  input wire logic       power_off_flag
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_idle_strobe: assert property (cpuHalt && pcRdata[0] && !cpuReset |-> addrStrobeOut && progStrobeOut)
    else $error("idle strobes not high");
  chk_pd_strobe: assert property (pcRdata[1] && !oscRun |-> !addrStrobeOut && !progStrobeOut)
    else $error("power-down strobes not low");
  chk_pd_osc: assert property ($rose(cpuHalt) && pcRdata[1] |-> !oscRun)
    else $error("oscillator runs in power-down");
  chk_halt_ram: assert property (cpuHalt && !cpuReset |-> !ramWriteEn)
    else $error("ram write while halted");
  chk_idle_exit: assert property (cpuHalt && pcRdata[0] && $rose(irqPending) |-> ##[1:4] cpuVector)
    else $error("idle not left on interrupt");
  chk_halt_entry: assert property (pcRdata[1:0] != 2'b00 && instrDone && !cpuHalt && !cpuReset && !floatMode
    |-> ##[1:3] cpuHalt)
    else $error("no halt after requesting instruction");
  chk_float_pins: assert property (floatMode |-> !port0Oe && weakPullUp && oscRun)
    else $error("float pins wrong");
  chk_reset_out: assert property (disable iff (1'b0) srst |=> cpuReset && regsReset && oscRun)
    else $error("reset outputs wrong");
  chk_flag_set: assert property ($rose(powerUp) |-> ##[1:4] power_off_flag)
    else $error("power-off flag not set");
  chk_gate_stop: assert property (!oscRun |-> !oscGate)
    else $error("clock gate open with oscillator stopped");
  cover property (cpuVector);
  cover property (floatMode);
  cover property (pcRdata[1] && !oscRun);
endmodule // lpm_ctrl_monitor

bind lpm_ctrl lpm_ctrl_monitor mon_u (.*);

// ===== bench/lpm_cpu_model.sv
// CPU core model retiring instructions while not halted.
// Assumes controller outputs change on the rising edge.
`timescale 1ns/1ps
module lpm_cpu_model #(
  parameter int GAP = 4
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // From controller
  input  wire logic cpuHalt,
  input  wire logic cpuReset,
  // To controller
  output logic      instrDone,
  output logic      ramWriteReq
);
  int cnt = 0;
  initial begin
    instrDone = 1'b0;
    ramWriteReq = 1'b0;
  end
  // Retire pulses only while running
  always @(negedge core_clk) begin
    instrDone = (cnt == GAP - 1) && !cpuHalt && !cpuReset && !srst;
    cnt = (cpuHalt || cpuReset || srst || cnt == GAP - 1) ? 0 : cnt + 1;
    // No write in the same slot as a retire
    ramWriteReq = !cpuHalt && !instrDone;
  end
endmodule // lpm_cpu_model

// ===== bench/test_lpm_ctrl.sv
// Testbench for lpm_ctrl with the CPU model.
// Assumes a short oscillator settle count.
`timescale 1ns/1ps
module test_lpm_ctrl;
  logic       core_clk, srst, powerUp, resetPin, pcWrite, irqPending, extProgMem;
  logic       ext_wake_irq_a, ext_wake_irq_b, wakeEnA, wakeEnB, addrStrobeIn, program_store_strobe;
  logic       instrDone, ramWriteReq, cpuHalt, cpuVector, cpuReset, ramWriteEn, regsReset, oscRun;
  logic       addrStrobeOut, progStrobeOut, port0Oe, port2Addr, weakPullUp, floatMode, power_off_flag;
  logic       oscGate, addrStrobeOe, progStrobeOe;
  logic [7:0] pcWdata, pcRdata;
  int         failures = 0, n_compared = 0, cyc = 0;
  lpm_cpu_model #(.GAP(3)) cpu_u (.core_clk(core_clk), .srst(srst), .cpuHalt(cpuHalt), .cpuReset(cpuReset),
    .instrDone(instrDone), .ramWriteReq(ramWriteReq));
  lpm_ctrl #(.OSC_SETTLE(20)) dut_u (.core_clk(core_clk), .srst(srst), .powerUp(powerUp), .resetPin(resetPin),
    .pcWrite(pcWrite), .pcWdata(pcWdata), .pcRdata(pcRdata), .instrDone(instrDone), .irqPending(irqPending),
    .ramWriteReq(ramWriteReq), .cpuHalt(cpuHalt), .cpuVector(cpuVector), .cpuReset(cpuReset),
    .ramWriteEn(ramWriteEn), .regsReset(regsReset), .oscRun(oscRun), .oscGate(oscGate),
    .ext_wake_irq_a(ext_wake_irq_a), .ext_wake_irq_b(ext_wake_irq_b), .wakeEnA(wakeEnA), .wakeEnB(wakeEnB),
    .extProgMem(extProgMem), .addrStrobeIn(addrStrobeIn), .program_store_strobe(program_store_strobe),
    .addrStrobeOut(addrStrobeOut), .addrStrobeOe(addrStrobeOe), .progStrobeOut(progStrobeOut),
    .progStrobeOe(progStrobeOe), .port0Oe(port0Oe), .port2Addr(port2Addr), .weakPullUp(weakPullUp),
    .floatMode(floatMode), .power_off_flag(power_off_flag));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ----
  // Tasks
  // ----
  task cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task pcw(input logic [7:0] d);
    @(negedge core_clk);
    pcWrite = 1'b1;
    pcWdata = d;
    @(negedge core_clk);
    pcWrite = 1'b0;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return cpuHalt;
      1: return cpuVector;
      2: return oscRun;
      3: return cpuReset;
      default: return floatMode;
    endcase
  endfunction
  task waitSig(input int w, input logic lvl);
    for (int i = 0; i < 200 && sel(w) !== lvl; i++) @(negedge core_clk);
    cmp("wait", 8'(lvl), 8'(sel(w)));
  endtask
  task give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    {srst, wakeEnA, extProgMem, addrStrobeIn, program_store_strobe, ext_wake_irq_a, ext_wake_irq_b} = 7'h7f;
    {powerUp, resetPin, pcWrite, irqPending, wakeEnB} = 5'h00;
    pcWdata = 8'h00;
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    powerUp = 1'b1;
    waitSig(3, 1'b0);
    repeat (4) @(negedge core_clk);
    cmp("flag", 8'h01, 8'(power_off_flag));
    pcw(8'h00);
    repeat (2) @(negedge core_clk);
    cmp("flag", 8'h00, 8'(power_off_flag));
    pcw(8'h10);
    repeat (2) @(negedge core_clk);
    cmp("pc", 8'h10, pcRdata);
    pcw(8'h11);
    waitSig(0, 1'b1);
    cmp("idle pins", 8'h1d, 8'({addrStrobeOut, progStrobeOut, oscRun, port0Oe, port2Addr}));
    cmp("ram en", 8'h00, 8'(ramWriteEn));
    irqPending = 1'b1;
    waitSig(1, 1'b1);
    irqPending = 1'b0;
    waitSig(0, 1'b0);
    cmp("pc", 8'h10, pcRdata);
    pcw(8'h12);
    waitSig(0, 1'b1);
    cmp("pd pins", 8'h00, 8'({addrStrobeOut, progStrobeOut, oscRun, port0Oe, port2Addr, oscGate}));
    ext_wake_irq_b = 1'b0;
    irqPending = 1'b1;
    repeat (30) @(negedge core_clk);
    cmp("osc halt", 8'h01, 8'({oscRun, cpuHalt}));
    irqPending = 1'b0;
    ext_wake_irq_b = 1'b1;
    ext_wake_irq_a = 1'b0; // held past settle
    waitSig(2, 1'b1);
    cmp("osc gate", 8'h00, 8'(oscGate));
    repeat (40) @(negedge core_clk);
    cmp("osc gate", 8'h01, 8'(oscGate));
    cmp("pc", 8'h12, pcRdata);
    ext_wake_irq_a = 1'b1;
    waitSig(1, 1'b1);
    repeat (2) @(negedge core_clk);
    cmp("pc", 8'h10, pcRdata);
    cmp("regs rst", 8'h00, 8'(regsReset));
    pcw(8'h11);
    waitSig(0, 1'b1);
    resetPin = 1'b1;
    repeat (10) begin
      @(negedge core_clk);
      cmp("ram en", 8'h00, 8'(ramWriteEn));
    end
    waitSig(3, 1'b1);
    cmp("regs rst", 8'h01, 8'(regsReset));
    resetPin = 1'b0;
    waitSig(3, 1'b0);
    pcw(8'h12);
    waitSig(0, 1'b1);
    resetPin = 1'b1;
    waitSig(3, 1'b1);
    cmp("regs rst", 8'h01, 8'(regsReset));
    addrStrobeIn = 1'b0;
    repeat (5) @(negedge core_clk);
    resetPin = 1'b0;
    waitSig(4, 1'b1);
    cmp("float pins", 8'h0c, 8'({port0Oe, weakPullUp, oscRun, addrStrobeOe, progStrobeOe}));
    addrStrobeIn = 1'b1;
    repeat (5) @(negedge core_clk);
    cmp("float", 8'h01, 8'(floatMode));
    resetPin = 1'b1;
    repeat (5) @(negedge core_clk);
    resetPin = 1'b0;
    waitSig(4, 1'b0);
    give_verdict();
  end
endmodule // test_lpm_ctrl
